/* src/wgc_pkg.sv */
// Constants and types of the waveform generator control register bank.
// Assumes an APB slave with a 32-bit data bus and one clock.
package wgc_pkg;

    // Byte offset of the single control register.
    localparam logic [11:0] WGC_CTRL0_OFFSET = 12'h000;

    // Width of the control register.
    localparam int WGC_REG_W = 8;

    // Field positions inside the control register.
    localparam int WGC_EN_POS = 7;
    localparam int WGC_OEB_POS = 6;
    localparam int WGC_OEA_POS = 5;
    localparam int WGC_POLB_POS = 4;
    localparam int WGC_POLA_POS = 3;
    localparam int WGC_CS_POS = 0;

    // Value of the control register after any reset.
    localparam logic [7:0] WGC_CTRL0_RESET = 8'h00;

    // Mask of the bits that software may change; bits 2 and 1 stay zero.
    localparam logic [7:0] WGC_CTRL0_WMASK = 8'hf9;

    // Number of output channels: index 0 primary, index 1 complementary.
    localparam int WGC_CHANNELS = 2;

    // Clock source encoding of the select bit.
    typedef enum logic
    {
        WGC_CLK_SYSTEM_OSC,
        WGC_CLK_INTERNAL_FAST_OSC
    } wgc_clk_src_t;

    // Layout of the control register.
    typedef struct packed
    {
        logic wave_gen_enable;
        logic complementary_out_pin_enable;
        logic primary_out_pin_enable;
        logic complementary_out_invert;
        logic primary_out_invert;
        logic [1:0] reserved;
        logic generator_clock_select;
    } wgc_ctrl0_t;

    // Controls handed to one output stage.
    typedef struct packed
    {
        logic run;
        logic invert;
        logic pin_enable;
    } wgc_stage_ctrl_t;

endpackage : wgc_pkg

/* src/wgc_out_stage.sv */
// One output stage: gating by the enable, polarity and pin enable.
// Assumes the raw waveform is synchronous to pclk.
`timescale 1ns/1ns
module wgc_out_stage
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic raw_wave,
    input wire wgc_pkg::wgc_stage_ctrl_t ctrl,
    output logic pin_out,
    output logic pin_oe
);
    import wgc_pkg::*;

    logic next_pin_out;

    // A stopped generator leaves only the idle level, which the invert bit still shapes.
    always_comb
    begin
        next_pin_out = (raw_wave & ctrl.run) ^ ctrl.invert;
    end

    // Pin level comes from a flip-flop so that it never glitches.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out <= 1'b0;
        end
        else
        begin
            pin_out <= next_pin_out;
        end
    end

    // The stage drives its pin only while its pin enable is set.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_oe <= 1'b0;
        end
        else
        begin
            pin_oe <= ctrl.pin_enable;
        end
    end

endmodule : wgc_out_stage

/* src/wgc_ctrl_reg0.sv */
// Control register 0 of the complementary waveform generator, an APB slave.
// Assumes a single clock, APB inputs synchronous to pclk, raw waves from the core.
// The output stages add one cycle of latency from the register to the pins.
// Bits 2 and 1 are unimplemented and always read as zero.
`timescale 1ns/1ns
// Summary of operation
// - Enable bit 7 set runs the generator; clear holds it disabled.
// - Complementary output reaches its pin only while bit 6 is set.
// - Primary output reaches its pin only while bit 5 is set.
// - Bit 4 set inverts the complementary output; clear keeps normal polarity.
// - Bit 3 set inverts the primary output; clear keeps normal polarity.
module wgc_ctrl_reg0
#(
    parameter int ADDR_W = 12
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic primary_output,
    input wire logic complementary_output,
    output logic wave_gen_enable,
    output wgc_pkg::wgc_clk_src_t generator_clock_select,
    output logic primary_pin,
    output logic primary_pin_oe,
    output logic complementary_pin,
    output logic complementary_pin_oe
);
    import wgc_pkg::*;

    // The decoder compares at least the register's word address bits.
    if (ADDR_W < 3 || ADDR_W > 32)
    begin : g_bad_addr_w
        $error("ADDR_W must lie between 3 and 32");
    end

    wgc_ctrl0_t ctrl0;
    logic hit;
    logic setup_rd;
    logic access;
    logic wr_ok;
    logic [WGC_CHANNELS-1:0] raw_wave;
    logic [WGC_CHANNELS-1:0] pin_out;
    logic [WGC_CHANNELS-1:0] pin_oe;
    wgc_stage_ctrl_t [WGC_CHANNELS-1:0] stage_ctrl;

    // Address decode and phase qualifiers of the APB transfer.
    // The offset is cast to the address width so that any address width decodes in full.
    // A write without the low byte strobe is accepted but leaves the register alone.
    assign hit = (paddr == ADDR_W'(WGC_CTRL0_OFFSET));
    assign setup_rd = psel && !penable && !pwrite;
    assign access = psel && penable;
    assign wr_ok = access && pwrite && hit && pstrb[0];

    // The slave never waits; an unmapped address ends in an error answer.
    assign pready = 1'b1;
    assign pslverr = access && !hit;

    // Register write: only the implemented bits change, reserved bits stay zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl0 <= wgc_ctrl0_t'(WGC_CTRL0_RESET);
        end
        else if (wr_ok)
        begin
            ctrl0 <= wgc_ctrl0_t'(pwdata[WGC_REG_W-1:0] & WGC_CTRL0_WMASK);
        end
    end

    // Read data is captured in the setup cycle and held through the access phase.
    // Capturing early keeps the read multiplexer out of the access cycle's timing.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
        end
        else if (setup_rd)
        begin
            prdata <= hit ? {24'h000000, ctrl0} : 32'h00000000;
        end
    end

    // Controls toward the generator core.
    assign wave_gen_enable = ctrl0.wave_gen_enable;
    assign generator_clock_select = wgc_clk_src_t'(ctrl0.generator_clock_select);

    // Channel 0 is the primary output, channel 1 the complementary one.
    assign raw_wave = {complementary_output, primary_output};
    assign stage_ctrl[0] = '{run: ctrl0.wave_gen_enable,
                             invert: ctrl0.primary_out_invert,
                             pin_enable: ctrl0.primary_out_pin_enable};
    assign stage_ctrl[1] = '{run: ctrl0.wave_gen_enable,
                             invert: ctrl0.complementary_out_invert,
                             pin_enable: ctrl0.complementary_out_pin_enable};

    // One identical output stage per channel.
    generate
        for (genvar ch = 0; ch < WGC_CHANNELS; ch++)
        begin : g_stage
            wgc_out_stage u_stage
            (
                .pclk(pclk),
                .presetn(presetn),
                .raw_wave(raw_wave[ch]),
                .ctrl(stage_ctrl[ch]),
                .pin_out(pin_out[ch]),
                .pin_oe(pin_oe[ch])
            );
        end
    endgenerate

    // Pin outputs of the two channels.
    // Pin enables ignore the generator enable, so a stopped generator still holds its idle level.
    assign primary_pin = pin_out[0];
    assign primary_pin_oe = pin_oe[0];
    assign complementary_pin = pin_out[1];
    assign complementary_pin_oe = pin_oe[1];

    // Checks of the register and output behaviour.
    // All checks share the register clock and are off while reset is low.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // A write of the enable bit shows on the generator enable one cycle later.
    a_enable_follows_write: assert property (
        wr_ok |=> wave_gen_enable == $past(pwdata[WGC_EN_POS]))
        else $error("generator enable does not follow written bit");

    // A stopped generator keeps the primary pin at its idle polarity level.
    a_disabled_idle_level: assert property (
        !wave_gen_enable ##1 !$past(wr_ok) |-> primary_pin == ctrl0.primary_out_invert)
        else $error("primary pin moves while generator disabled");

    // A stopped generator keeps the complementary pin at its idle polarity level.
    a_comp_idle_level: assert property (
        !wave_gen_enable ##1 !$past(wr_ok)
            |-> complementary_pin == ctrl0.complementary_out_invert)
        else $error("complementary pin moves while generator disabled");

    // The complementary pin enable follows its control bit with one cycle of lag.
    a_comp_pin_gate: assert property (
        ##1 complementary_pin_oe == $past(ctrl0.complementary_out_pin_enable))
        else $error("complementary pin enable wrong");

    // The primary pin enable follows its control bit with one cycle of lag.
    a_prim_pin_gate: assert property (
        ##1 primary_pin_oe == $past(ctrl0.primary_out_pin_enable))
        else $error("primary pin enable wrong");

    // The complementary pin carries the gated wave, inverted when asked.
    a_comp_polarity: assert property (
        ##1 complementary_pin ==
            ($past(complementary_output & wave_gen_enable)
             ^ $past(ctrl0.complementary_out_invert)))
        else $error("complementary polarity wrong");

    // The primary pin carries the gated wave, inverted when asked.
    a_prim_polarity: assert property (
        ##1 primary_pin ==
            ($past(primary_output & wave_gen_enable) ^ $past(ctrl0.primary_out_invert)))
        else $error("primary polarity wrong");

    // Reserved bits read zero and the clock select tracks the written bit.
    a_reserved_read_zero: assert property (
        access && !pwrite |-> prdata[2:1] == 2'b00 && prdata[31:8] == 24'h000000)
        else $error("reserved bits read nonzero");

    a_clock_sel_write: assert property (
        wr_ok |=> generator_clock_select == wgc_clk_src_t'($past(pwdata[WGC_CS_POS])))
        else $error("clock select does not follow written bit");

    // An unmapped access answers with an error and changes nothing.
    a_unmapped_error: assert property (
        access && !hit |-> pslverr ##1 $stable(ctrl0))
        else $error("unmapped access not refused");

    // After any reset the register is clear and both pins are idle and undriven.
    a_reset_clears: assert property (
        $rose(presetn) |-> ctrl0 == WGC_CTRL0_RESET && !primary_pin && !complementary_pin
            && !primary_pin_oe && !complementary_pin_oe)
        else $error("state after reset not clear");

    // Only a mapped write with the low byte strobe may change the register.
    a_no_stray_change: assert property (
        !wr_ok |=> $stable(ctrl0))
        else $error("register changed without a mapped write");

    // A mapped write lands with the reserved bits forced to zero.
    a_write_lands: assert property (
        wr_ok |=> ctrl0 == ($past(pwdata[WGC_REG_W-1:0]) & WGC_CTRL0_WMASK))
        else $error("written value not stored");

    // The reserved field never holds a one.
    a_reserved_bits_zero: assert property (
        ctrl0.reserved == 2'b00)
        else $error("reserved bits set");

    // A read answers with the register in the low byte, or zero when unmapped.
    a_read_data: assert property (
        access && !pwrite |-> prdata == (hit ? {24'h000000, ctrl0} : 32'h00000000))
        else $error("read data wrong");

    // Main scenarios.
    c_enable_on: cover property (wr_ok && pwdata[WGC_EN_POS] ##1 wave_gen_enable);
    c_read_back: cover property (access && !pwrite && hit && prdata[WGC_EN_POS]);
    c_inverted_run: cover property (wave_gen_enable && ctrl0.primary_out_invert ##2 primary_pin_oe);
    c_unmapped: cover property (pslverr);
    c_fast_clock: cover property (wr_ok && pwdata[WGC_CS_POS]
        ##1 generator_clock_select == WGC_CLK_INTERNAL_FAST_OSC);

endmodule : wgc_ctrl_reg0

/* test/tb_top.sv */
// Self-checking bench for control register 0 of the waveform generator.
// Assumes an APB slave that answers in its own time and pins that follow one cycle late.
`timescale 1ns/1ns
module tb_top;
    import wgc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'h0;
    logic raw_a = 1'b0;
    logic raw_b = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, pa, pa_oe, pb, pb_oe, gen_en;
    wgc_clk_src_t clk_sel;
    int mismatches = 0;
    int checked = 0;
    int seed = 12677;
    logic [31:0] model = 32'h00000000;

    wgc_ctrl_reg0 #(.ADDR_W(12)) wgc_ctrl_reg0_inst
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .primary_output(raw_a), .complementary_output(raw_b),
        .wave_gen_enable(gen_en), .generator_clock_select(clk_sel),
        .primary_pin(pa), .primary_pin_oe(pa_oe),
        .complementary_pin(pb), .complementary_pin_oe(pb_oe)
    );

    // The clock toggles every 20 ns, a period of 40 ns.
    always #20 pclk = ~pclk;

    // Prints the counts and the verdict, then stops the run.
    task automatic complete_run();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // Compares one bus result.
    task automatic cmp_bus(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_bus

    // Compares the control outputs and pins as one vector.
    task automatic cmp_out(input logic [5:0] got, input logic [5:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t outputs got %b exp %b", $time, got, exp);
        end
    endtask : cmp_out

    // One APB transfer; entered right after a rising edge, it returns one idle edge
    // after the answer, so that the next call never reassigns a strobe in one step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Drives every raw wave pair and checks gating, polarity and pin enables.
    task automatic check_outs();
        logic [5:0] exp;
        logic [5:0] got;
        for (int k = 0; k < 4; k++)
        begin
            raw_a <= k[0];
            raw_b <= k[1];
            repeat (2) @(posedge pclk);
            exp = {model[7], model[0], model[5], (k[0] & model[7]) ^ model[3],
                   model[6], (k[1] & model[7]) ^ model[4]};
            got = {gen_en, clk_sel, pa_oe, pa, pb_oe, pb};
            cmp_out(got, exp);
        end
    endtask : check_outs

    // Main sequence: reset, random writes with read-back, a second reset.
    initial
    begin
        logic [31:0] r;
        logic [31:0] d;
        logic [11:0] a;
        logic [3:0] s;
        logic e;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_outs();
        for (int i = 0; i < 40; i++)
        begin
            d = (i == 0) ? 32'h000000ff : (i == 1) ? 32'h00000006 : $random(seed);
            s = (i < 2) ? 4'hf : 4'($random(seed));
            a = (i < 2 || {$random(seed)} % 3 != 0) ? 12'h000 :
                12'(({$random(seed)} % 1023 + 1) * 4);
            apb(1'b1, a, d, s, r, e);
            cmp_bus({31'h0, e}, {31'h0, a != 12'h000}, "write error");
            if (a == 12'h000 && s[0])
                model = d & {24'h0, WGC_CTRL0_WMASK};
            apb(1'b0, a, 32'h0, 4'h0, r, e);
            cmp_bus({31'h0, e}, {31'h0, a != 12'h000}, "read error");
            cmp_bus(r, (a == 12'h000) ? model : 32'h0, "read data");
            check_outs();
        end
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        model = 32'h0;
        @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0, 4'h0, r, e);
        cmp_bus(r, 32'h0, "value after reset");
        check_outs();
        complete_run();
    end

    // Watchdog that cuts a hung run short.
    initial
    begin
        #200000;
        mismatches++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        complete_run();
    end
endmodule : tb_top
